// File: ibl_pkg.sv
// Constants and carrier types for the in-band loop code generator/detector.
// Assumes a byte-wide register port and one line bit per clock in each direction.
`default_nettype none

package ibl_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_LOOP_STAT = 8'hb5;
	localparam logic [7:0] ADDR_IB_CTRL   = 8'hb6;
	localparam logic [7:0] ADDR_TX_PAT_HI = 8'hb7;
	localparam logic [7:0] ADDR_TX_PAT_LO = 8'hb8;
	localparam logic [7:0] ADDR_UP_PAT_HI = 8'hb9;
	localparam logic [7:0] ADDR_UP_PAT_LO = 8'hba;
	localparam logic [7:0] ADDR_DN_PAT_HI = 8'hbb;
	localparam logic [7:0] ADDR_DN_PAT_LO = 8'hbc;

	// Values after reset
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic       BIT_RESET = 1'b0;

	// Field positions
	localparam int TX_SEL_HI_POS  = 7;
	localparam int TX_SEL_LO_POS  = 6;
	localparam int ARM_LEN_POS    = 3;
	localparam int DISARM_LEN_POS = 0;
	localparam int TX_EN_POS      = 0;
	localparam int UP_FLAG_POS    = 1;
	localparam int DN_FLAG_POS    = 2;

	// Transmit length selections, lengths in bits and the detector's long length code
	localparam logic [1:0] TX_SEL_5  = 2'h0;
	localparam logic [1:0] TX_SEL_6  = 2'h1;
	localparam logic [1:0] TX_SEL_7  = 2'h2;
	localparam logic [4:0] LEN_5     = 5'h05;
	localparam logic [4:0] LEN_6     = 5'h06;
	localparam logic [4:0] LEN_7     = 5'h07;
	localparam logic [4:0] LEN_16    = 5'h10;
	localparam logic [2:0] LEN_CODE_LONG = 3'h7;

	// Integration period in matched line bits
	localparam int CNT_W      = 16;
	localparam int INTEG_BITS = 1000;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ibl_req_t;

endpackage

`default_nettype wire

// File: ibl_loop_code.sv
// In-band repeating loop code generator and up/down code detectors.
// Assumes register strobes, line inputs and MCLK are synchronous; one line bit per clock.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ibl_code_detect #(
	parameter int INTEG = ibl_pkg::INTEG_BITS
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Received line bit
	input  wire logic        bit_in,
	// Pattern setup
	input  wire logic [15:0] pattern,
	input  wire logic [2:0]  len_code,
	input  wire logic        restart,
	// Result
	output logic             detect
);
	import ibl_pkg::*;

	localparam logic [CNT_W-1:0] INTEG_C = CNT_W'(INTEG);

	logic [15:0]      hist;
	logic [4:0]       fill;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             rot_hit;

	wire logic [4:0] len;
	wire logic       win_full;

	assign len = (len_code == LEN_CODE_LONG) ? LEN_16 : {2'b00, len_code} + 5'h01;
	assign win_full = (fill >= len);

	// Phase-free search: the newest len bits must equal some rotation of the pattern.
	// Only the top len bits of the pattern are looked at.
	always_comb begin : rot_search
		int  idx;
		logic ok;
		idx = 0;
		ok = 1'b0;
		rot_hit = 1'b0;
		for (int k = 0; k < 16; k++) begin
			ok = (k < int'(len));
			for (int j = 0; j < 16; j++) begin
				if (j < int'(len)) begin
					idx = k + j;
					if (idx >= int'(len))
						idx = idx - int'(len);
					if (hist[int'(len) - 1 - j] != pattern[15 - idx])
						ok = 1'b0;
				end
			end
			if (ok)
				rot_hit = 1'b1;
		end
	end

	always_comb begin
		next_cnt = '0;
		if (restart)
			next_cnt = '0;
		else if (win_full && rot_hit)
			next_cnt = (cnt == INTEG_C) ? cnt : cnt + 1'b1;
	end

	// Restart also empties the window so stale bits cannot count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hist   <= '0;
			fill   <= '0;
			cnt    <= '0;
			detect <= 1'b0;
		end else begin
			hist   <= {hist[14:0], bit_in};
			fill   <= restart ? 5'h00 : ((fill == LEN_16) ? fill : fill + 5'h01);
			cnt    <= next_cnt;
			detect <= !restart && (next_cnt == INTEG_C);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	restart_clear_a: assert property (restart |=> cnt == '0 && !detect && fill == 5'h00)
		else $error("restart did not clear integration");
	detect_rise_a: assert property ($rose(detect) |-> cnt == INTEG_C && $past(cnt) == INTEG_C - 1'b1)
		else $error("detect rose before full integration");
	miss_drop_a: assert property (!(win_full && rot_hit) |=> !detect)
		else $error("detect held through a mismatch");
	len_short_a: assert property (len_code != LEN_CODE_LONG |-> len == {2'b00, len_code} + 5'h01)
		else $error("short length decode wrong");
	// Counting waits for a full window; a held match keeps the flag
	fill_wait_a: assert property (!win_full |=> cnt == '0 && !detect)
		else $error("integration counted before the window filled");
	detect_hold_a: assert property (detect && win_full && rot_hit && !restart |=> detect)
		else $error("detect dropped during a match");

endmodule // ibl_code_detect

module ibl_loop_code (
	// Clock and reset
	input  wire logic              MCLK,
	input  wire logic              RESET,
	// Register port
	input  wire ibl_pkg::ibl_req_t REG_REQ,
	output logic [7:0]             RDATA,
	// Transmit line
	input  wire logic              TX_LINE_IN,
	output logic                   TX_LINE_OUT,
	// Receive line and detection
	input  wire logic              RX_LINE_IN,
	output logic                   UP_DETECT,
	output logic                   DOWN_DETECT
);
	import ibl_pkg::*;

	logic [7:0] ib_ctrl;
	logic [7:0] tx_pat_hi;
	logic [7:0] tx_pat_lo;
	logic [7:0] up_pat_hi;
	logic [7:0] up_pat_lo;
	logic [7:0] dn_pat_hi;
	logic [7:0] dn_pat_lo;
	logic       tx_en;
	logic [3:0] tx_idx;
	logic [3:0] next_tx_idx;
	logic [4:0] quiet;

	// Write and read decode
	wire logic       wr_stat;
	wire logic       wr_ctrl;
	wire logic       wr_tx_hi;
	wire logic       wr_tx_lo;
	wire logic       wr_up_hi;
	wire logic       wr_up_lo;
	wire logic       wr_dn_hi;
	wire logic       wr_dn_lo;
	wire logic [7:0] stat_val;
	wire logic [7:0] rd_sel;

	assign wr_stat  = REG_REQ.wr && (REG_REQ.addr == ADDR_LOOP_STAT);
	assign wr_ctrl  = REG_REQ.wr && (REG_REQ.addr == ADDR_IB_CTRL);
	assign wr_tx_hi = REG_REQ.wr && (REG_REQ.addr == ADDR_TX_PAT_HI);
	assign wr_tx_lo = REG_REQ.wr && (REG_REQ.addr == ADDR_TX_PAT_LO);
	assign wr_up_hi = REG_REQ.wr && (REG_REQ.addr == ADDR_UP_PAT_HI);
	assign wr_up_lo = REG_REQ.wr && (REG_REQ.addr == ADDR_UP_PAT_LO);
	assign wr_dn_hi = REG_REQ.wr && (REG_REQ.addr == ADDR_DN_PAT_HI);
	assign wr_dn_lo = REG_REQ.wr && (REG_REQ.addr == ADDR_DN_PAT_LO);

	assign stat_val = {5'h00, DOWN_DETECT, UP_DETECT, tx_en};

	// Unmapped addresses read as zero
	assign rd_sel = (REG_REQ.addr == ADDR_LOOP_STAT) ? stat_val :
	                (REG_REQ.addr == ADDR_IB_CTRL)   ? ib_ctrl :
	                (REG_REQ.addr == ADDR_TX_PAT_HI) ? tx_pat_hi :
	                (REG_REQ.addr == ADDR_TX_PAT_LO) ? tx_pat_lo :
	                (REG_REQ.addr == ADDR_UP_PAT_HI) ? up_pat_hi :
	                (REG_REQ.addr == ADDR_UP_PAT_LO) ? up_pat_lo :
	                (REG_REQ.addr == ADDR_DN_PAT_HI) ? dn_pat_hi :
	                (REG_REQ.addr == ADDR_DN_PAT_LO) ? dn_pat_lo : 8'h00;

	// Control fields
	wire logic       tx_len_sel_hi;
	wire logic       tx_len_sel_lo;
	wire logic       arm_len_sel_b2;
	wire logic       arm_len_sel_b1;
	wire logic       arm_len_sel_b0;
	wire logic       disarm_len_sel_b2;
	wire logic       disarm_len_sel_b1;
	wire logic       disarm_len_sel_b0;
	wire logic [1:0] tx_sel;
	wire logic [4:0] tx_len;
	wire logic       pattern_first_bit;
	wire logic [15:0] tx_pat;

	assign tx_len_sel_hi     = ib_ctrl[TX_SEL_HI_POS];
	assign tx_len_sel_lo     = ib_ctrl[TX_SEL_LO_POS];
	assign arm_len_sel_b2    = ib_ctrl[ARM_LEN_POS + 2];
	assign arm_len_sel_b1    = ib_ctrl[ARM_LEN_POS + 1];
	assign arm_len_sel_b0    = ib_ctrl[ARM_LEN_POS];
	assign disarm_len_sel_b2 = ib_ctrl[DISARM_LEN_POS + 2];
	assign disarm_len_sel_b1 = ib_ctrl[DISARM_LEN_POS + 1];
	assign disarm_len_sel_b0 = ib_ctrl[DISARM_LEN_POS];
	assign tx_sel            = {tx_len_sel_hi, tx_len_sel_lo};

	// 6 covers 3, 16 covers 8/4/2/1 by repeating the shorter code in the pattern
	assign tx_len = (tx_sel == TX_SEL_5) ? LEN_5 :
	                (tx_sel == TX_SEL_6) ? LEN_6 :
	                (tx_sel == TX_SEL_7) ? LEN_7 : LEN_16;

	assign pattern_first_bit = tx_pat_hi[7];
	assign tx_pat            = {tx_pat_hi, tx_pat_lo};

	// Index passes len-1 only for one cycle after a write shortens the length, so ignored bits are touched only then
	assign next_tx_idx = (!tx_en || ({1'b0, tx_idx} >= tx_len - 5'h01)) ? 4'h0 : tx_idx + 4'h1;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ib_ctrl   <= REG_RESET;
			tx_pat_hi <= REG_RESET;
			tx_pat_lo <= REG_RESET;
			up_pat_hi <= REG_RESET;
			up_pat_lo <= REG_RESET;
			dn_pat_hi <= REG_RESET;
			dn_pat_lo <= REG_RESET;
			tx_en     <= BIT_RESET;
		end else begin
			if (wr_ctrl)
				ib_ctrl <= REG_REQ.wdata;
			if (wr_tx_hi)
				tx_pat_hi <= REG_REQ.wdata;
			if (wr_tx_lo)
				tx_pat_lo <= REG_REQ.wdata;
			if (wr_up_hi)
				up_pat_hi <= REG_REQ.wdata;
			if (wr_up_lo)
				up_pat_lo <= REG_REQ.wdata;
			if (wr_dn_hi)
				dn_pat_hi <= REG_REQ.wdata;
			if (wr_dn_lo)
				dn_pat_lo <= REG_REQ.wdata;
			if (wr_stat)
				tx_en <= REG_REQ.wdata[TX_EN_POS];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET)
			RDATA <= 8'h00;
		else
			RDATA <= REG_REQ.rd ? rd_sel : 8'h00;
	end

	// Generator: disabled means the line passes straight through
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			tx_idx      <= 4'h0;
			TX_LINE_OUT <= 1'b0;
		end else begin
			tx_idx      <= next_tx_idx;
			TX_LINE_OUT <= tx_en ? tx_pat[4'hf - tx_idx] : TX_LINE_IN;
		end
	end

	ibl_code_detect u_up (
		.clk      (MCLK),
		.rst      (RESET),
		.bit_in   (RX_LINE_IN),
		.pattern  ({up_pat_hi, up_pat_lo}),
		.len_code ({arm_len_sel_b2, arm_len_sel_b1, arm_len_sel_b0}),
		.restart  (wr_up_hi),
		.detect   (UP_DETECT)
	);

	ibl_code_detect u_dn (
		.clk      (MCLK),
		.rst      (RESET),
		.bit_in   (RX_LINE_IN),
		.pattern  ({dn_pat_hi, dn_pat_lo}),
		.len_code ({disarm_len_sel_b2, disarm_len_sel_b1, disarm_len_sel_b0}),
		.restart  (wr_dn_hi),
		.detect   (DOWN_DETECT)
	);

	// Helper for period checks: cycles since last write or disable
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET)
			quiet <= 5'h00;
		else if (REG_REQ.wr || !tx_en)
			quiet <= 5'h00;
		else if (quiet != 5'h1f)
			quiet <= quiet + 5'h01;
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	gen_first_bit_a: assert property (tx_en && tx_idx == 4'h0 |=> TX_LINE_OUT == $past(pattern_first_bit))
		else $error("first generated bit is not bit 7");
	gen_wrap_a: assert property (tx_en && quiet != 5'h00 && {1'b0, tx_idx} == tx_len - 5'h01 |=> tx_idx == 4'h0)
		else $error("generator did not wrap");
	gen_step_a: assert property (tx_en && {1'b0, tx_idx} < tx_len - 5'h01 && !REG_REQ.wr
		|=> tx_idx == $past(tx_idx) + 4'h1)
		else $error("generator skipped a bit");
	tx_short5_a: assert property (quiet != 5'h00 && tx_sel == TX_SEL_5 |-> tx_idx < 4'h5)
		else $error("5-bit code reached ignored bits");
	tx_low_ign_a: assert property (quiet != 5'h00 && tx_sel != 2'h3 |-> tx_idx < 4'h7)
		else $error("short code reached low byte");
	tx_short6_a: assert property (quiet != 5'h00 && tx_sel == TX_SEL_6 |-> tx_idx < 4'h6)
		else $error("6-bit code reached ignored bits");
	gen_hold_a: assert property (!tx_en |=> tx_idx == 4'h0 && TX_LINE_OUT == $past(TX_LINE_IN))
		else $error("disabled generator not parked at the first bit");
	// Period checks wait 31 quiet cycles so a fresh setting has settled
	tx_period5_a: assert property (quiet == 5'h1f && tx_sel == TX_SEL_5
		|-> TX_LINE_OUT == $past(TX_LINE_OUT, 5))
		else $error("5-bit code period wrong");
	tx_period6_a: assert property (quiet == 5'h1f && tx_sel == TX_SEL_6
		|-> TX_LINE_OUT == $past(TX_LINE_OUT, 6))
		else $error("6-bit code period wrong");
	tx_period7_a: assert property (quiet == 5'h1f && tx_sel == TX_SEL_7
		|-> TX_LINE_OUT == $past(TX_LINE_OUT, 7))
		else $error("7-bit code period wrong");
	tx_period16_a: assert property (quiet == 5'h1f && tx_sel == 2'h3
		|-> TX_LINE_OUT == $past(TX_LINE_OUT, 16))
		else $error("16-bit code period wrong");
	up_restart_a: assert property (wr_up_hi |=> !UP_DETECT)
		else $error("up write did not restart integration");
	dn_restart_a: assert property (wr_dn_hi |=> !DOWN_DETECT)
		else $error("down write did not restart integration");
	rd_data_a: assert property (REG_REQ.rd && REG_REQ.addr == ADDR_IB_CTRL && !$past(wr_ctrl)
		|=> RDATA == $past(ib_ctrl))
		else $error("control readback wrong");
	stat_read_a: assert property (REG_REQ.rd && REG_REQ.addr == ADDR_LOOP_STAT
		|=> RDATA == {5'h00, $past(DOWN_DETECT), $past(UP_DETECT), $past(tx_en)})
		else $error("status readback wrong");

	wrap16_c: cover property (tx_en && tx_sel == 2'h3 && tx_idx == 4'hf ##1 tx_idx == 4'h0);
	up_seen_c: cover property ($rose(UP_DETECT));
	dn_seen_c: cover property ($rose(DOWN_DETECT));
	restart_c: cover property (UP_DETECT && wr_up_hi);
	period5_c: cover property (quiet == 5'h1f && tx_sel == TX_SEL_5);

endmodule // ibl_loop_code

`default_nettype wire

// File: ibl_far_end.sv
// Far-end line partner: repeats a loop code on the receive line.
// Assumes the bench changes code and length only while reconfiguring the block.
`timescale 1ns/1ps
`default_nettype none

module ibl_far_end (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Code to send
	input  wire logic        en,
	input  wire logic [15:0] pattern,
	input  wire logic [4:0]  len,
	// Line
	output logic             line
);
	logic [4:0] idx;

	// Idle line toggles each bit so a stale code never looks like a match
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idx  <= 5'h00;
			line <= 1'b0;
		end else if (en) begin
			line <= pattern[4'hf - idx[3:0]];
			idx  <= (idx + 5'h01 >= len) ? 5'h00 : idx + 5'h01;
		end else begin
			line <= ~line;
			idx  <= 5'h00;
		end
	end
endmodule // ibl_far_end

`default_nettype wire

// File: ibl_tb.sv
// Self-checking bench for the in-band loop code generator and detectors.
// Assumes ibl_pkg and ibl_far_end are compiled first; full-length integration.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ibl_pkg::*;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} ibl_row_t;

	// Ignored low bits of the high byte differ from bit 7, so an overrun shows
	localparam logic [15:0] TX_PAT = 16'hb83c;

	logic        mclk        = 1'b0;
	logic        reset       = 1'b1;
	ibl_req_t    req         = '0;
	logic [7:0]  rdata;
	logic        tx_in       = 1'b0;
	logic        tx_prev     = 1'b0;
	logic        tx_out;
	logic        rx_line;
	logic        up_det;
	logic        dn_det;
	logic        fe_en       = 1'b0;
	logic [15:0] fe_pat      = 16'h0000;
	logic [4:0]  fe_len      = 5'h01;
	logic [4:0]  cur_len;
	int          err_total   = 0;
	int          checks_done = 0;
	int          n;
	logic [4:0]  lens [4]    = '{LEN_5, LEN_6, LEN_7, LEN_16};
	ibl_row_t    rows [11]   = '{'{8'hb6, 8'hff, 8'hff}, '{8'hb7, 8'ha5, 8'ha5}, '{8'hb8, 8'h5a, 8'h5a},
		'{8'hb9, 8'hc3, 8'hc3}, '{8'hba, 8'h3c, 8'h3c}, '{8'hbb, 8'h81, 8'h81}, '{8'hbc, 8'h7e, 8'h7e},
		'{8'hb5, 8'hff, 8'h01}, '{8'hb5, 8'h00, 8'h00}, '{8'hbd, 8'h55, 8'h00}, '{8'hb6, 8'h00, 8'h00}};

	always #50 mclk = ~mclk;

	// Upstream data toggles so the disabled pass-through is visible
	always @(posedge mclk) begin
		tx_in   <= ~tx_in;
		tx_prev <= tx_in;
	end

	ibl_loop_code DUT (
		.MCLK       (mclk),
		.RESET      (reset),
		.REG_REQ    (req),
		.RDATA      (rdata),
		.TX_LINE_IN (tx_in),
		.TX_LINE_OUT(tx_out),
		.RX_LINE_IN (rx_line),
		.UP_DETECT  (up_det),
		.DOWN_DETECT(dn_det)
	);

	ibl_far_end far (
		.clk    (mclk),
		.rst    (reset),
		.en     (fe_en),
		.pattern(fe_pat),
		.len    (fe_len),
		.line   (rx_line)
	);

	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (!ok) begin
			err_total++;
			$display("CHECK FAILED at %0t ns: %s", $time, msg);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		req.wr <= 1'b0;
		#1;
	endtask

	// Read data stand one cycle only, then return to zero
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		req.rd <= 1'b0;
		#1 check(rdata === e, "read data");
		@(posedge mclk);
		#1 check(rdata === 8'h00, "read data not cleared");
	endtask

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
		for (int a = 8'hb5; a <= 8'hbc; a++)
			rd(8'(a), REG_RESET);
		repeat (4) begin
			check(tx_out === tx_prev, "pass-through");
			@(posedge mclk);
			#1;
		end
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].exp);
		end
		$display("register test done");
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_TX_PAT_HI, TX_PAT[15:8]);
			wr(ADDR_TX_PAT_LO, TX_PAT[7:0]);
			wr(ADDR_IB_CTRL, {2'(s), 6'h00});
			wr(ADDR_LOOP_STAT, 8'h01);
			@(posedge mclk);
			#1;
			// Long enough for the period checks to see a settled pattern
			for (int i = 0; i < 48; i++) begin
				check(tx_out === TX_PAT[4'hf - 4'(i % lens[s])], "tx bit");
				@(posedge mclk);
				#1;
			end
			wr(ADDR_LOOP_STAT, 8'h00);
		end
		$display("generator test done");
		for (int c = 0; c < 8; c++) begin
			cur_len = (c == 7) ? LEN_16 : 5'(c + 1);
			fe_pat <= 16'hb4d2;
			fe_len <= cur_len;
			fe_en  <= 1'b1;
			wr(ADDR_IB_CTRL, {2'b00, 3'(c), 3'(c)});
			// Bits beyond the length are written inverted; only the long code uses the low byte
			wr(ADDR_UP_PAT_LO, (c == 7) ? 8'hd2 : 8'h2d);
			wr(ADDR_DN_PAT_LO, (c == 7) ? 8'hd2 : 8'h2d);
			wr(ADDR_UP_PAT_HI, 8'hb4 ^ (8'hff >> cur_len));
			wr(ADDR_DN_PAT_HI, 8'hb4 ^ (8'hff >> cur_len));
			n = 0;
			while (!(up_det === 1'b1 && dn_det === 1'b1) && n < INTEG_BITS + 64) begin
				@(posedge mclk);
				#1 n++;
			end
			check(up_det === 1'b1 && dn_det === 1'b1, "code not detected");
			check(n >= INTEG_BITS - 8, "detect before integration");
			if (n >= INTEG_BITS + 64)
				finish_test();
		end
		rd(ADDR_LOOP_STAT, 8'h06);
		wr(ADDR_UP_PAT_HI, 8'hb4);
		@(posedge mclk);
		#1 check(up_det === 1'b0 && dn_det === 1'b1, "up restart");
		wr(ADDR_DN_PAT_HI, 8'hb4);
		@(posedge mclk);
		#1 check(dn_det === 1'b0, "down restart");
		$display("detector test done");
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1 check(up_det === 1'b0 && dn_det === 1'b0 && tx_out === tx_prev, "outputs after mid-run reset");
		rd(ADDR_IB_CTRL, REG_RESET);
		rd(ADDR_UP_PAT_HI, REG_RESET);
		$display("mid-run reset test done");
		finish_test();
	end
endmodule // testbench

`default_nettype wire
